// ===== core/pdm_pkg.sv
// Purpose: shared constants and types of the pre-driver mode controller
// Assumes: one eight-bit command per device on the serial chain
// Notes:   field positions and calibration scale live here only
package pdm_pkg;
   localparam int PH_N      = 3;
   localparam int CMD_W     = 8;
   localparam int OP_W      = 3;
   localparam int DAT_W     = 5;
   localparam int NIB_W     = 4;
   localparam int CNT_W     = 3;
   localparam int SEL_W     = 2;
   localparam int OP_LSB    = 5;
   localparam int GRP_BIT   = 4;
   localparam int CAL_W     = 12;
   localparam int CAL_SHIFT = 4;

   localparam logic [OP_W-1:0]  OP_NULL  = 3'h0;
   localparam logic [OP_W-1:0]  OP_MASK  = 3'h1;
   localparam logic [OP_W-1:0]  OP_MODE  = 3'h2;
   localparam logic [OP_W-1:0]  OP_CLR   = 3'h3;
   localparam logic [OP_W-1:0]  OP_DEAD  = 3'h4;
   localparam logic [SEL_W-1:0] SEL_SR0  = 2'h0;
   localparam logic [NIB_W-1:0] MASK_RST = 4'hf;
   localparam logic [DAT_W-1:0] DEAD_RST = 5'h00;

   // protection-mode command data bits
   localparam int MODE_PROT = 0;
   localparam int MODE_FULL = 1;
   localparam int MODE_LOCK = 2;

   // fault latch group zero
   localparam int F0_OT    = 0;
   localparam int F0_DESAT = 1;
   localparam int F0_UV    = 2;
   localparam int F0_OC    = 3;
   // fault latch group one
   localparam int F1_PHASE = 0;
   localparam int F1_FRAME = 1;
   localparam int F1_WERR  = 2;
   localparam int F1_RSV   = 3;

   typedef enum logic [4:0] {
      PDM_SLEEP   = 5'h01,
      PDM_STANDBY = 5'h02,
      PDM_INIT    = 5'h04,
      PDM_ENABLE  = 5'h08,
      PDM_FAULT   = 5'h10
   } pdm_mode_t;

   typedef struct packed {
      logic [PH_N-1:0] hs;
      logic [PH_N-1:0] ls;
   } pdm_gate_t;

   typedef struct packed {
      logic ot;
      logic desat;
      logic uv;
      logic oc;
      logic phase;
   } pdm_fault_t;
endpackage

// ===== core/pdm_predriver_ctrl.sv
// Purpose: operating modes and serial command decoder of a gate pre-driver
// Assumes: serial mode 0, SCLK and CS_N far slower than MCLK
// Notes:   all inputs but RSTN and CE pass two flops; status word shifts out MSB first
`timescale 1ns/10ps

// Function
// - global reset low holds sleep, gates off weakly, clears faults and port.
// - in sleep all logic outputs are low except weak pulldown.
// - reset high with an enable low is standby, gates held off, port works.
// - in standby serial data out is driven only while chip select low.
// - reset and both enables high enter init, low sides follow commands.
// - host toggles low side then high side of a phase; enable follows.
// - enable mode gates follow the direct commands while enables stay high.
// - high side stays off until its phase low side has pulsed.
// - protective fault enters fault mode; recovery passes through init again.
// - fault mode turns all drivers off; the protection setting chooses which faults enter it.
// - open low-side, fault, enable, reset, data, clock inputs low; others high.
// - command is the last eight bits of the transfer, allowing chains.
// - top three bits are opcode, lower five bits are data.
// - bit count not a multiple of eight flags framing error, discards.
// - first response after reset is status register zero.
// - status read returns register zero to three and changes nothing.
// - two interrupt-enable commands load four enable bits from low nibble.
// - interrupt stays high while uncleared fault latch remains, despite mask rewrite.
// - latch-clear commands clear group latches chosen by ones in nibble.
// - protection-mode command sets protection, full conduction and optional lock.
// - dead-interval command sets dead interval by calibration.
// - enable, clear, mode and dead commands answer with status zero.
// - interrupt rises when an enabled fault latch becomes active.
// - latch clear acts on chip select rise and only without framing error.
module pdm_predriver_ctrl (
   input  wire logic                      MCLK,
   input  wire logic                      RSTN,
   input  wire logic                      CE,
   input  wire logic                      GLOBAL_RST_N,
   input  wire logic                      ENABLE_INPUT_A,
   input  wire logic                      ENABLE_INPUT_B,
   input  wire logic [pdm_pkg::PH_N-1:0]  LOW_SIDE_CMD_IN,
   input  wire logic [pdm_pkg::PH_N-1:0]  HIGH_SIDE_CMD_IN,
   input  wire pdm_pkg::pdm_fault_t       FAULT_IN,
   input  wire logic                      SCLK,
   input  wire logic                      CS_N,
   input  wire logic                      SI,
   output      pdm_pkg::pdm_gate_t        GATE_OUT,
   output      logic                      WEAK_PULLDOWN,
   output      logic                      IRQ_OUT,
   output      logic                      SO_O,
   output      logic                      SO_OE,
   output      pdm_pkg::pdm_mode_t        MODE_OUT,
   output      logic [pdm_pkg::DAT_W-1:0] DEAD_TIME_OUT,
   output      logic                      FULL_ON_OUT
);
   localparam int PH   = pdm_pkg::PH_N;
   localparam int NIB  = pdm_pkg::NIB_W;
   localparam int CMDW = pdm_pkg::CMD_W;
   localparam int SGL  = 6;
   localparam int SW   = $bits(pdm_pkg::pdm_fault_t) + 2 * PH + SGL;
   localparam int DIVW = pdm_pkg::CAL_W - pdm_pkg::CAL_SHIFT;
   // pin default levels when undriven
   localparam logic [SW-1:0] SYNC_INIT = {
      {$bits(pdm_pkg::pdm_fault_t){1'h0}}, {PH{1'h0}}, {PH{1'h1}},
      1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0};

   // ---------------- input synchronisers ----------------
   logic [SW-1:0]       raw;
   logic [SW-1:0]       s1_q;
   logic [SW-1:0]       s2_q;
   pdm_pkg::pdm_fault_t flt;
   logic [PH-1:0]       ls_in;
   logic [PH-1:0]       hs_in;
   logic                en_a;
   logic                en_b;
   logic                grst_n;
   logic                sclk;
   logic                cs_n;
   logic                si;

   assign raw = {FAULT_IN, LOW_SIDE_CMD_IN, HIGH_SIDE_CMD_IN,
                 ENABLE_INPUT_A, ENABLE_INPUT_B, GLOBAL_RST_N,
                 SCLK, CS_N, SI};
   assign {flt, ls_in, hs_in, en_a, en_b, grst_n, sclk, cs_n, si} = s2_q;

   always_ff @(posedge MCLK) begin
      if (!RSTN) begin
         s1_q <= SYNC_INIT;
         s2_q <= SYNC_INIT;
      end else if (CE) begin
         s1_q <= raw;
         s2_q <= s1_q;
      end
   end

   // ---------------- edge history ----------------
   logic          sclk_q;
   logic          cs_q;
   logic [PH-1:0] ls_q;
   logic [PH-1:0] hs_q;
   logic          lrst;

   // global reset pin acts as a synchronous clear of all but the input synchronisers
   assign lrst = !RSTN || !grst_n;

   always_ff @(posedge MCLK) begin
      if (lrst) begin
         sclk_q <= 1'h0;
         cs_q   <= 1'h1;
         ls_q   <= '0;
         hs_q   <= '1;
      end else if (CE) begin
         sclk_q <= sclk;
         cs_q   <= cs_n;
         ls_q   <= ls_in;
         hs_q   <= hs_in;
      end
   end

   // ---------------- serial port ----------------
   logic                       sck_rise;
   logic                       sck_fall;
   logic                       cs_fall;
   logic                       cs_rise;
   logic                       sel;
   logic [CMDW-1:0]            shreg_q;
   logic [pdm_pkg::CNT_W-1:0]  cnt_q;
   logic                       any_q;
   logic                       so_q;
   logic                       oe_q;
   logic [pdm_pkg::SEL_W-1:0]  rsel_q;
   logic [CMDW-1:0]            resp;
   logic [CMDW-1:0]            sr0;
   logic [CMDW-1:0]            sr1;
   logic [CMDW-1:0]            sr2;
   logic [CMDW-1:0]            sr3;
   logic                       frame_ok;
   logic                       frame_err;
   logic                       exec;

   assign sck_rise  = sclk & ~sclk_q;
   assign sck_fall  = ~sclk & sclk_q;
   assign cs_fall   = ~cs_n & cs_q;
   assign cs_rise   = cs_n & ~cs_q;
   assign sel       = ~cs_n;
   // empty frames carry no command and raise no error
   assign frame_ok  = any_q && (cnt_q == '0);
   assign frame_err = cs_rise && any_q && (cnt_q != '0);
   assign exec      = cs_rise && frame_ok;
   assign resp      = (rsel_q == 2'h0) ? sr0 :
                      (rsel_q == 2'h1) ? sr1 :
                      (rsel_q == 2'h2) ? sr2 : sr3;

   // ---------------- command decode ----------------
   logic [pdm_pkg::OP_W-1:0]  opc;
   logic [pdm_pkg::DAT_W-1:0] dat;
   logic [NIB-1:0]            nib;
   logic                      grp;
   logic                      is_null;
   logic                      is_mask;
   logic                      is_mode;
   logic                      is_clr;
   logic                      is_dead;
   logic [pdm_pkg::SEL_W-1:0] nsel;

   assign opc     = shreg_q[CMDW-1:pdm_pkg::OP_LSB];
   assign dat     = shreg_q[pdm_pkg::DAT_W-1:0];
   assign nib     = shreg_q[NIB-1:0];
   assign grp     = shreg_q[pdm_pkg::GRP_BIT];
   assign is_null = opc == pdm_pkg::OP_NULL;
   assign is_mask = opc == pdm_pkg::OP_MASK;
   assign is_mode = opc == pdm_pkg::OP_MODE;
   assign is_clr  = opc == pdm_pkg::OP_CLR;
   assign is_dead = opc == pdm_pkg::OP_DEAD;
   // every other command answers with status zero next time
   assign nsel    = is_null ? shreg_q[pdm_pkg::SEL_W-1:0]
                            : pdm_pkg::SEL_SR0;

   always_ff @(posedge MCLK) begin
      if (lrst) begin
         shreg_q <= '0;
         cnt_q   <= '0;
         any_q   <= 1'h0;
         so_q    <= 1'h0;
         oe_q    <= 1'h0;
         rsel_q  <= pdm_pkg::SEL_SR0;
      end else if (CE) begin
         oe_q <= sel;
         if (cs_fall) begin
            shreg_q <= resp;
            cnt_q   <= '0;
            any_q   <= 1'h0;
            so_q    <= resp[CMDW-1];
         end else if (sel && sck_rise) begin
            // older bits fall out the top toward the next device
            shreg_q <= {shreg_q[CMDW-2:0], si};
            cnt_q   <= cnt_q + 3'h1;
            any_q   <= 1'h1;
         end else if (sel && sck_fall) begin
            so_q <= shreg_q[CMDW-1];
         end
         if (exec) begin
            rsel_q <= nsel;
         end
      end
   end

   // ---------------- configuration ----------------
   logic [NIB-1:0]            irq_enable_grp0_cmd_q;
   logic [NIB-1:0]            irq_enable_grp1_cmd_q;
   logic                      prot_q;
   logic                      full_q;
   logic                      lock_q;
   logic [pdm_pkg::DAT_W-1:0] dead_q;
   logic                      cal_arm_q;
   logic [pdm_pkg::CAL_W-1:0] cal_q;
   logic [DIVW-1:0]           cal_div;
   logic [pdm_pkg::DAT_W-1:0] dead_cal;
   logic                      mode_wr;
   logic                      werr;

   assign mode_wr  = exec && is_mode && !lock_q;
   assign werr     = exec && is_mode && lock_q;
   assign cal_div  = cal_q[pdm_pkg::CAL_W-1:pdm_pkg::CAL_SHIFT];
   // saturate the measured interval to the field width
   assign dead_cal = (|cal_div[DIVW-1:pdm_pkg::DAT_W]) ? '1
                     : cal_div[pdm_pkg::DAT_W-1:0];

   always_ff @(posedge MCLK) begin
      if (lrst) begin
         irq_enable_grp0_cmd_q   <= pdm_pkg::MASK_RST;
         irq_enable_grp1_cmd_q   <= pdm_pkg::MASK_RST;
         prot_q    <= 1'h0;
         full_q    <= 1'h0;
         lock_q    <= 1'h0;
         dead_q    <= pdm_pkg::DEAD_RST;
         cal_arm_q <= 1'h0;
         cal_q     <= '0;
      end else if (CE) begin
         if (exec && is_mask && !grp) begin
            irq_enable_grp0_cmd_q <= nib;
         end
         if (exec && is_mask && grp) begin
            irq_enable_grp1_cmd_q <= nib;
         end
         if (mode_wr) begin
            prot_q <= dat[pdm_pkg::MODE_PROT];
            full_q <= dat[pdm_pkg::MODE_FULL];
            lock_q <= dat[pdm_pkg::MODE_LOCK];
         end
         // next chip-select low pulse is the calibration interval
         if (exec && is_dead) begin
            cal_arm_q <= 1'h1;
            cal_q     <= '0;
         end else if (cal_arm_q && cs_rise) begin
            cal_arm_q <= 1'h0;
            dead_q    <= dead_cal;
         end else if (cal_arm_q && sel && !(&cal_q)) begin
            cal_q <= cal_q + 12'h001;
         end
      end
   end

   // ---------------- fault latches and interrupt ----------------
   logic [NIB-1:0] ev0;
   logic [NIB-1:0] ev1;
   logic [NIB-1:0] lat0_q;
   logic [NIB-1:0] lat1_q;
   logic [NIB-1:0] snap0_q;
   logic [NIB-1:0] snap1_q;
   logic [NIB-1:0] clr0;
   logic [NIB-1:0] clr1;
   logic [NIB-1:0] lat0_d;
   logic [NIB-1:0] lat1_d;
   logic [NIB-1:0] arm0_q;
   logic [NIB-1:0] arm1_q;
   logic [NIB-1:0] arm0_d;
   logic [NIB-1:0] arm1_d;
   logic           irq_d;
   pdm_pkg::pdm_mode_t mode_q;

   assign ev0[pdm_pkg::F0_OT]    = flt.ot;
   assign ev0[pdm_pkg::F0_DESAT] = flt.desat;
   assign ev0[pdm_pkg::F0_UV]    = flt.uv;
   assign ev0[pdm_pkg::F0_OC]    = flt.oc;
   // phase latch input is blanked in full-conduction mode; fault-mode entry still sees it
   assign ev1[pdm_pkg::F1_PHASE] = flt.phase && !full_q;
   assign ev1[pdm_pkg::F1_FRAME] = frame_err;
   assign ev1[pdm_pkg::F1_WERR]  = werr;
   assign ev1[pdm_pkg::F1_RSV]   = 1'h0;
   // only faults already reported at chip-select fall may be cleared
   assign clr0 = {NIB{exec && is_clr && !grp}} & nib & snap0_q;
   assign clr1 = {NIB{exec && is_clr && grp}} & nib & snap1_q;
   // a live fault re-sets its latch in the same cycle as a clear
   assign lat0_d = (lat0_q & ~clr0) | ev0;
   assign lat1_d = (lat1_q & ~clr1) | ev1;
   // once enabled, a latch keeps the interrupt until it is cleared
   assign arm0_d = (arm0_q & lat0_d) | (lat0_d & irq_enable_grp0_cmd_q);
   assign arm1_d = (arm1_q & lat1_d) | (lat1_d & irq_enable_grp1_cmd_q);
   assign irq_d  = |{arm0_d, arm1_d};

   assign sr0 = {lat1_q, lat0_q};
   assign sr1 = {mode_q, lock_q, full_q, prot_q};
   assign sr2 = {irq_enable_grp1_cmd_q, irq_enable_grp0_cmd_q};
   assign sr3 = {3'h0, dead_q};

   always_ff @(posedge MCLK) begin
      if (lrst) begin
         lat0_q  <= '0;
         lat1_q  <= '0;
         snap0_q <= '0;
         snap1_q <= '0;
         arm0_q  <= '0;
         arm1_q  <= '0;
      end else if (CE) begin
         lat0_q <= lat0_d;
         lat1_q <= lat1_d;
         arm0_q <= arm0_d;
         arm1_q <= arm1_d;
         if (cs_fall) begin
            snap0_q <= lat0_q;
            snap1_q <= lat1_q;
         end
      end
   end

   // ---------------- operating mode ----------------
   pdm_pkg::pdm_mode_t mode_d;
   logic               both_en;
   logic               prot_flt;
   logic [PH-1:0]      ls_seen_q;
   logic [PH-1:0]      armed_q;
   logic               init_done;

   assign both_en   = en_a && en_b;
   // desat and phase stop the drivers only with protection enabled
   assign prot_flt  = flt.uv || (prot_q && (flt.desat || flt.phase));
   assign init_done = |(ls_seen_q & (hs_in ^ hs_q));

   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         pdm_pkg::PDM_SLEEP: begin
            mode_d = pdm_pkg::PDM_STANDBY;
         end
         pdm_pkg::PDM_STANDBY: begin
            if (both_en) begin
               mode_d = pdm_pkg::PDM_INIT;
            end
         end
         pdm_pkg::PDM_INIT: begin
            if (!both_en) begin
               mode_d = pdm_pkg::PDM_STANDBY;
            end else if (prot_flt) begin
               mode_d = pdm_pkg::PDM_FAULT;
            end else if (init_done) begin
               mode_d = pdm_pkg::PDM_ENABLE;
            end
         end
         pdm_pkg::PDM_ENABLE: begin
            if (!both_en) begin
               mode_d = pdm_pkg::PDM_STANDBY;
            end else if (prot_flt) begin
               mode_d = pdm_pkg::PDM_FAULT;
            end
         end
         pdm_pkg::PDM_FAULT: begin
            if (!both_en) begin
               mode_d = pdm_pkg::PDM_STANDBY;
            end else if (!prot_flt) begin
               mode_d = pdm_pkg::PDM_INIT;
            end
         end
         default: begin
            mode_d = pdm_pkg::PDM_SLEEP;
         end
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (lrst) begin
         mode_q <= pdm_pkg::PDM_SLEEP;
      end else if (CE) begin
         mode_q <= mode_d;
      end
   end

   // ---------------- per-phase gate logic ----------------
   pdm_pkg::pdm_gate_t gate_d;
   pdm_pkg::pdm_gate_t gate_q;
   logic               in_init;
   logic               in_en;
   logic               go_init;
   logic               go_en;

   assign in_init = mode_q == pdm_pkg::PDM_INIT;
   assign in_en   = mode_q == pdm_pkg::PDM_ENABLE;
   // gates switch on the same edge as the mode register, never behind it
   assign go_init = mode_d == pdm_pkg::PDM_INIT;
   assign go_en   = mode_d == pdm_pkg::PDM_ENABLE;

   genvar p;
   generate
      for (p = 0; p < PH; p++) begin : g_ph
         // without full conduction a double command in enable mode turns both off
         assign gate_d.ls[p] = (go_init && ls_in[p]) ||
                               (go_en && ls_in[p] &&
                                (full_q || !hs_in[p]));
         assign gate_d.hs[p] = go_en && hs_in[p] && armed_q[p] &&
                               (full_q || !ls_in[p]);

         always_ff @(posedge MCLK) begin
            if (lrst) begin
               ls_seen_q[p] <= 1'h0;
               armed_q[p]   <= 1'h0;
            end else if (CE) begin
               if (!in_init) begin
                  ls_seen_q[p] <= 1'h0;
               end else if (ls_in[p] != ls_q[p]) begin
                  ls_seen_q[p] <= 1'h1;
               end
               // bootstrap charge needs a finished low-side pulse
               if (!in_en) begin
                  armed_q[p] <= 1'h0;
               end else if (ls_q[p] && !ls_in[p]) begin
                  armed_q[p] <= 1'h1;
               end
            end
         end
      end
   endgenerate

   // ---------------- output registers ----------------
   logic irq_q;
   logic wpd_q;

   // standby, fault and sleep all leave gate_d low
   always_ff @(posedge MCLK) begin
      if (lrst) begin
         gate_q <= '0;
         irq_q  <= 1'h0;
         wpd_q  <= 1'h1;
      end else if (CE) begin
         gate_q <= gate_d;
         irq_q  <= irq_d;
         wpd_q  <= mode_d == pdm_pkg::PDM_SLEEP;
      end
   end

   assign GATE_OUT      = gate_q;
   assign WEAK_PULLDOWN = wpd_q;
   assign IRQ_OUT       = irq_q;
   assign SO_O          = so_q;
   assign SO_OE         = oe_q;
   assign MODE_OUT      = mode_q;
   assign DEAD_TIME_OUT = dead_q;
   assign FULL_ON_OUT   = full_q;
endmodule

// ===== verif/pdm_host_model.sv
// Purpose: serial master side of the host controller
// Assumes: serial mode 0, 64 ns clock period
// Notes:   serial clock stands low between frames
`timescale 1ns/10ps
module pdm_host_model (
   input  logic SO_O,
   input  logic SO_OE,
   output logic SCLK,
   output logic CS_N,
   output logic SI
);
   // a released line reads as the inverse of the last bit
   wire logic so_seen = SO_OE ? SO_O : ~SO_O;

   initial begin
      SCLK = 1'b0;
      CS_N = 1'b1;
      SI   = 1'b0;
   end

   // n bits msb first, reply shifted into r
   task automatic xfer(input int n, input logic [15:0] d,
                       output logic [15:0] r);
      r = 16'h0000;
      CS_N = 1'b0;
      #104;
      for (int i = n - 1; i >= 0; i--) begin
         SI = d[i];
         #32 SCLK = 1'b1;
         // late sample covers the pin synchroniser lag
         #32 r = {r[14:0], so_seen};
         SCLK = 1'b0;
      end
      #40 CS_N = 1'b1;
      SI = ~SI;
      #104;
   endtask

   // select pulse with no clocks, length in 8 ns steps
   task automatic pulse(input int cyc);
      CS_N = 1'b0;
      #(cyc * 8);
      CS_N = 1'b1;
      #104;
   endtask
endmodule

// ===== verif/pdm_monitor.sv
// Purpose: port assertions of the pre-driver controller
// Assumes: checks paused while CE is low, one clock domain
// Notes:   bound into every controller instance
`timescale 1ns/10ps
module pdm_monitor (
   input logic                MCLK,
   input logic                RSTN,
   input logic                CE,
   input logic                GLOBAL_RST_N,
   input logic                ENABLE_INPUT_A,
   input logic                ENABLE_INPUT_B,
   input pdm_pkg::pdm_fault_t FAULT_IN,
   input logic                CS_N,
   input pdm_pkg::pdm_gate_t  GATE_OUT,
   input logic                WEAK_PULLDOWN,
   input logic                IRQ_OUT,
   input logic                SO_OE,
   input pdm_pkg::pdm_mode_t  MODE_OUT
);
   logic       cs_q;
   logic [3:0] since_q;
   logic [3:0] since_d;
   wire logic  both_en = ENABLE_INPUT_A && ENABLE_INPUT_B;

   // cycles since chip select last rose, saturating
   assign since_d = (CS_N && !cs_q) ? 4'h0
                  : since_q + {3'h0, since_q != 4'hf};
   always_ff @(posedge MCLK) begin
      cs_q    <= CS_N;
      since_q <= RSTN ? since_d : 4'hf;
   end

   default clocking @(posedge MCLK);
   endclocking
   default disable iff (!RSTN || !CE);

   a_sleep_quiet: assert property (
      MODE_OUT == pdm_pkg::PDM_SLEEP |->
         GATE_OUT == '0 && !IRQ_OUT && WEAK_PULLDOWN)
      else $error("outputs active in sleep");
   a_rst_sleep: assert property (
      !GLOBAL_RST_N [*5] |-> MODE_OUT == pdm_pkg::PDM_SLEEP)
      else $error("reset pin did not give sleep");
   a_standby_mode: assert property (
      (GLOBAL_RST_N && !both_en) [*5] |->
         MODE_OUT == pdm_pkg::PDM_STANDBY)
      else $error("standby not entered");
   a_standby_off: assert property (
      MODE_OUT == pdm_pkg::PDM_STANDBY |-> GATE_OUT == '0)
      else $error("gate on in standby");
   a_so_quiet: assert property (
      CS_N [*6] |-> !SO_OE)
      else $error("serial out driven while deselected");
   a_so_drive: assert property (
      (!CS_N && MODE_OUT != pdm_pkg::PDM_SLEEP) [*6] |-> SO_OE)
      else $error("serial out not driven while selected");
   a_init_entry: assert property (
      MODE_OUT == pdm_pkg::PDM_STANDBY && both_en && GLOBAL_RST_N
         |-> ##[1:5] MODE_OUT == pdm_pkg::PDM_INIT)
      else $error("init not entered");
   a_uv_fault: assert property (
      $rose(FAULT_IN.uv) && MODE_OUT == pdm_pkg::PDM_ENABLE
         |-> ##[1:6] MODE_OUT == pdm_pkg::PDM_FAULT)
      else $error("undervoltage gave no fault mode");
   a_fault_off: assert property (
      MODE_OUT == pdm_pkg::PDM_FAULT |-> GATE_OUT.hs == 3'h0)
      else $error("high side on in fault mode");
   a_irq_hold: assert property (
      $fell(IRQ_OUT) |->
         since_q < 4'hc || MODE_OUT == pdm_pkg::PDM_SLEEP)
      else $error("interrupt fell without a clear");
endmodule

bind pdm_predriver_ctrl pdm_monitor i_mon (
   .MCLK, .RSTN, .CE, .GLOBAL_RST_N, .ENABLE_INPUT_A, .ENABLE_INPUT_B,
   .FAULT_IN, .CS_N, .GATE_OUT, .WEAK_PULLDOWN, .IRQ_OUT, .SO_OE,
   .MODE_OUT
);

// ===== verif/testbench.sv
// Purpose: self-checking bench of the pre-driver controller
// Assumes: host model drives the serial port
// Notes:   mask, mode and dead settings carry across tests
`timescale 1ns/10ps
module testbench;
   logic                mclk, rstn, ce, grst_n, en_a, en_b;
   logic                sclk, cs_n, si, so, so_oe, wpd, irq, full;
   logic [2:0]          ls, hs;
   logic [4:0]          dead;
   logic [15:0]         r;
   pdm_pkg::pdm_fault_t fault;
   pdm_pkg::pdm_gate_t  gate;
   pdm_pkg::pdm_mode_t  mode;
   int                  mismatches = 0;
   int                  n_tests = 0;

   pdm_predriver_ctrl i_dut (
      .MCLK(mclk), .RSTN(rstn), .CE(ce), .GLOBAL_RST_N(grst_n),
      .ENABLE_INPUT_A(en_a), .ENABLE_INPUT_B(en_b),
      .LOW_SIDE_CMD_IN(ls), .HIGH_SIDE_CMD_IN(hs), .FAULT_IN(fault),
      .SCLK(sclk), .CS_N(cs_n), .SI(si), .GATE_OUT(gate),
      .WEAK_PULLDOWN(wpd), .IRQ_OUT(irq), .SO_O(so), .SO_OE(so_oe),
      .MODE_OUT(mode), .DEAD_TIME_OUT(dead), .FULL_ON_OUT(full));
   pdm_host_model i_host (
      .SO_O(so), .SO_OE(so_oe), .SCLK(sclk), .CS_N(cs_n), .SI(si));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic sp(input logic [7:0] d, input logic [7:0] exp);
      i_host.xfer(8, {8'h00, d}, r);
      chk(r[7:0], exp);
   endtask

   task automatic drv(input logic [2:0] l, input logic [2:0] h);
      ls = l;
      hs = h;
      cyc(8);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic t_sleep;
      grst_n = 1'b0;
      cyc(8);
      chk(8'(mode), 8'h01);
      chk({2'h0, gate}, 8'h00);
      chk({5'h00, wpd, irq, so_oe}, 8'h04);
      chk({2'h0, full, dead}, 8'h00);
      $display("test sleep done");
   endtask

   task automatic t_standby;
      grst_n = 1'b1;
      cyc(8);
      chk(8'(mode), 8'h02);
      chk({6'h00, wpd, so_oe}, 8'h00);
      sp(8'h25, 8'h00);
      $display("test standby done");
   endtask

   task automatic t_masks;
      sp(8'h3a, 8'h00);
      sp(8'h02, 8'h00);
      sp(8'h02, 8'ha5);
      sp(8'h00, 8'ha5);
      sp(8'h00, 8'h00);
      $display("test masks done");
   endtask

   task automatic t_frame;
      i_host.xfer(7, 16'h0000, r);
      sp(8'h00, 8'h20);
      chk({7'h00, irq}, 8'h01);
      sp(8'h30, 8'h20);
      chk({7'h00, irq}, 8'h01);
      sp(8'h72, 8'h20);
      cyc(8);
      chk({7'h00, irq}, 8'h00);
      sp(8'h00, 8'h00);
      $display("test framing done");
   endtask

   task automatic t_chain;
      i_host.xfer(16, 16'hff02, r);
      chk(r[15:8], 8'h00);
      chk(r[7:0], 8'hff);
      sp(8'he0, 8'h05);
      sp(8'h00, 8'h00);
      $display("test chain done");
   endtask

   task automatic t_mode;
      sp(8'h46, 8'h00);
      sp(8'h41, 8'h00);
      sp(8'h01, 8'h40);
      sp(8'h00, 8'h16);
      chk({7'h00, full}, 8'h01);
      $display("test mode done");
   endtask

   task automatic t_dead;
      sp(8'h80, 8'h40);
      i_host.pulse(328);
      cyc(8);
      chk({3'h0, dead}, 8'h14);
      $display("test dead done");
   endtask

   task automatic t_enable;
      en_a = 1'b1;
      en_b = 1'b1;
      cyc(8);
      chk(8'(mode), 8'h04);
      drv(3'h1, 3'h0);
      drv(3'h0, 3'h0);
      drv(3'h0, 3'h1);
      drv(3'h0, 3'h0);
      chk(8'(mode), 8'h08);
      drv(3'h0, 3'h2);
      chk({2'h0, gate}, 8'h00);
      drv(3'h2, 3'h0);
      chk({2'h0, gate}, 8'h02);
      drv(3'h0, 3'h2);
      chk({2'h0, gate}, 8'h10);
      $display("test enable done");
   endtask

   task automatic t_fault;
      // clock enable low freezes the whole block
      ce = 1'b0;
      fault.uv = 1'b1;
      cyc(8);
      chk(8'(mode), 8'h08);
      chk({2'h0, gate}, 8'h10);
      ce = 1'b1;
      cyc(8);
      chk(8'(mode), 8'h10);
      chk({2'h0, gate}, 8'h00);
      chk({7'h00, irq}, 8'h01);
      fault.uv = 1'b0;
      cyc(8);
      chk(8'(mode), 8'h04);
      $display("test fault done");
   endtask

   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      grst_n = 1'b1;
      en_a = 1'b0;
      en_b = 1'b0;
      ls = 3'h0;
      hs = 3'h0;
      fault = '0;
      cyc(20);
      rstn = 1'b1;
      t_sleep;
      t_standby;
      t_masks;
      t_frame;
      t_chain;
      t_mode;
      t_dead;
      t_enable;
      t_fault;
      t_sleep;
      results;
   end

   // about ten times the expected run
   initial begin
      #200000;
      mismatches++;
      results;
   end
endmodule
